// File: rtl/lit_alu_regs.svh
`ifndef LIT_ALU_REGS_SVH
`define LIT_ALU_REGS_SVH

// Opcode fields, instruction word bits 13:10, 13:9, 13:8 or 13:7; option-load is the whole word
`define OP_ADD_LIT 5'h1f
`define OP_SUB_LIT 5'h1e
`define OP_AND_LIT 6'h39
`define OP_OR_LIT 6'h38
`define OP_LOAD_LIT 4'hc
`define OP_ADD_FILE 6'h07
`define OP_AND_FILE 6'h05
`define OP_OR_FILE 6'h04
`define OP_INC_SKIP 6'h0f
`define OP_COPY_FILE 6'h08
`define OP_SUB_FILE 6'h02
`define OP_STORE_ACC 7'h01
`define OP_OPT_LOAD 14'h0062
`define NOP_WORD 14'h0000

// Reset values
`define ACC_RST 8'h00
`define OPT_RST 8'hff
`define FLAG_RST 1'h0

// Skip costs one extra instruction cycle
`define SKIP_CYCLES 1

`endif

// File: rtl/lit_alu_pkg.sv
package lit_alu_pkg;
  typedef enum logic [11:0] {
    OPC_NONE       = 12'h001,
    OPC_ADD_LIT    = 12'h002,
    OPC_SUB_LIT    = 12'h004,
    OPC_AND_LIT    = 12'h008,
    OPC_OR_LIT     = 12'h010,
    OPC_LOAD_LIT   = 12'h020,
    OPC_ADD_FILE   = 12'h040,
    OPC_AND_FILE   = 12'h080,
    OPC_OR_FILE    = 12'h100,
    OPC_INC_SKIP   = 12'h200,
    OPC_COPY_FILE  = 12'h400,
    OPC_SUB_FILE   = 12'h800
  } opclass_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'h1,
    ST_SKIP = 2'h2
  } exec_state_t;
endpackage

// File: rtl/add8_flags.sv
`timescale 1ns/1ps
// Eight-bit adder with carry and nibble carry
module add8_flags (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  // Result
  output logic [7:0] sum,
  output logic cout,
  output logic hcout
);
  logic [4:0] lo;
  logic [4:0] hi;
  assign lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
  assign sum = {hi[3:0], lo[3:0]};
  assign cout = hi[4];
  assign hcout = lo[4];
endmodule

// File: rtl/lit_file_alu.sv
`timescale 1ns/1ps
`include "lit_alu_regs.svh"
// --------------------------------------------------------------
// Overview of operation
// - Add literal to accumulator, carries and zero
// - AND literal into accumulator, Z only
// - Add accumulator and file, carries and zero
// - Destination bit zero accumulator, one file
// - AND accumulator with file, Z only
// - Increment file, flags untouched
// - Zero result discards next, two cycles
// - OR accumulator with file, Z only
// - OR literal into accumulator, Z only
// - Load literal into accumulator, no flags
// - Copy file to destination, Z updated
// - Store accumulator to file, no flags
// - Option-load copies accumulator, no flags
// - Literal minus accumulator, carries and zero
// - File minus accumulator, carries and zero
// - Subtract carry is inverted borrow
// --------------------------------------------------------------
module lit_file_alu
  import lit_alu_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Instruction from fetch stage, valid each cycle
  input wire logic [13:0] instr,
  // File register read data at the instruction's address
  input wire logic [DATA_W-1:0] file_rdata,
  // File register write port
  output logic [ADDR_W-1:0] file_addr,
  output logic file_we,
  output logic [DATA_W-1:0] file_wdata,
  // Architectural state
  output logic [DATA_W-1:0] acc,
  output logic [DATA_W-1:0] opt_cfg,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic zero_flag,
  // Skip indication to fetch stage
  output logic skip_active
);
  import lit_alu_pkg::*;

  if (DATA_W != 8 || ADDR_W != 7) begin : g_bad_width
    $error("lit_file_alu supports 8-bit data, 7-bit address only");
  end

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  function automatic opclass_t decode(input logic [13:0] w);
    opclass_t c;
    c = OPC_NONE;
    if (w[13:9] == `OP_ADD_LIT) c = OPC_ADD_LIT;
    else if (w[13:9] == `OP_SUB_LIT) c = OPC_SUB_LIT;
    else if (w[13:8] == `OP_AND_LIT) c = OPC_AND_LIT;
    else if (w[13:8] == `OP_OR_LIT) c = OPC_OR_LIT;
    else if (w[13:10] == `OP_LOAD_LIT) c = OPC_LOAD_LIT;
    else if (w[13:8] == `OP_ADD_FILE) c = OPC_ADD_FILE;
    else if (w[13:8] == `OP_AND_FILE) c = OPC_AND_FILE;
    else if (w[13:8] == `OP_OR_FILE) c = OPC_OR_FILE;
    else if (w[13:8] == `OP_INC_SKIP) c = OPC_INC_SKIP;
    else if (w[13:8] == `OP_COPY_FILE) c = OPC_COPY_FILE;
    else if (w[13:8] == `OP_SUB_FILE) c = OPC_SUB_FILE;
    return c;
  endfunction

  function automatic logic is_zero8(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  exec_state_t state_r;
  exec_state_t state_nxt;
  // Discarded word is replaced by a no-operation
  wire [13:0] word = (state_r == ST_SKIP) ? `NOP_WORD : instr;
  wire opclass_t cls = decode(word);
  wire dest_file = word[7];
  wire is_store = (word[13:7] == `OP_STORE_ACC);
  wire is_opt = (word == `OP_OPT_LOAD);
  wire [7:0] lit = word[7:0];
  wire is_lit = cls inside {OPC_ADD_LIT, OPC_SUB_LIT, OPC_AND_LIT, OPC_OR_LIT, OPC_LOAD_LIT};

  // --------------------------------------------------------------
  // Datapath
  // --------------------------------------------------------------
  // Subtraction as b + ~acc + 1, so carry out is the inverted borrow
  wire is_sub = (cls == OPC_SUB_LIT) || (cls == OPC_SUB_FILE);
  wire is_inc = (cls == OPC_INC_SKIP);
  wire [7:0] src_b = is_lit ? lit : file_rdata;
  wire [7:0] add_a = is_inc ? 8'h01 : (is_sub ? ~acc : acc);
  wire add_cin = is_sub;
  wire [7:0] add_sum;
  wire add_c;
  wire add_dc;

  add8_flags u_add (
    .a(add_a),
    .b(src_b),
    .cin(add_cin),
    .sum(add_sum),
    .cout(add_c),
    .hcout(add_dc)
  );

  logic [7:0] result;
  always_comb begin
    unique case (cls)
      OPC_ADD_LIT, OPC_SUB_LIT, OPC_ADD_FILE, OPC_SUB_FILE, OPC_INC_SKIP: result = add_sum;
      OPC_AND_LIT, OPC_AND_FILE: result = acc & src_b;
      OPC_OR_LIT, OPC_OR_FILE: result = acc | src_b;
      OPC_LOAD_LIT: result = lit;
      OPC_COPY_FILE: result = file_rdata;
      default: result = acc;
    endcase
  end

  wire arith = cls inside {OPC_ADD_LIT, OPC_SUB_LIT, OPC_ADD_FILE, OPC_SUB_FILE};
  wire set_z = arith || cls inside {OPC_AND_LIT, OPC_OR_LIT, OPC_AND_FILE, OPC_OR_FILE, OPC_COPY_FILE};
  wire file_op = cls inside {OPC_ADD_FILE, OPC_AND_FILE, OPC_OR_FILE, OPC_INC_SKIP, OPC_COPY_FILE, OPC_SUB_FILE};
  wire wr_file = (file_op && dest_file) || is_store;
  wire wr_acc = is_lit || (file_op && !dest_file);
  wire skip_take = is_inc && is_zero8(add_sum);

  // --------------------------------------------------------------
  // File write port
  // --------------------------------------------------------------
  assign file_addr = word[6:0];
  assign file_we = wr_file;
  assign file_wdata = is_store ? acc : result;
  assign skip_active = (state_r == ST_SKIP);

  // --------------------------------------------------------------
  // Sequencing: one cycle each, taken skip adds a no-op cycle
  // --------------------------------------------------------------
  always_comb begin
    unique case (state_r)
      ST_RUN: state_nxt = skip_take ? ST_SKIP : ST_RUN;
      ST_SKIP: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  logic [7:0] acc_nxt;
  logic [7:0] opt_nxt;
  assign acc_nxt = wr_acc ? result : acc;
  assign opt_nxt = is_opt ? acc : opt_cfg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_RUN;
      acc <= `ACC_RST;
      opt_cfg <= `OPT_RST;
    end else begin
      state_r <= state_nxt;
      acc <= acc_nxt;
      opt_cfg <= opt_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      carry_flag <= `FLAG_RST;
      half_carry_flag <= `FLAG_RST;
      zero_flag <= `FLAG_RST;
    end else begin
      if (arith) begin
        carry_flag <= add_c;
        half_carry_flag <= add_dc;
      end
      if (set_z) zero_flag <= is_zero8(result);
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_skip_taken;
    (state_r == ST_RUN) && is_inc && (file_rdata == 8'hff);
  endsequence

  a_skip_two_cycles: assert property (s_skip_taken |=> skip_active ##1 !skip_active)
    else $error("skip did not last exactly one extra cycle");
  a_inc_no_skip: assert property ((state_r == ST_RUN) && is_inc && file_rdata != 8'hff |=> !skip_active)
    else $error("skip taken on nonzero increment");
  a_add_lit_acc: assert property (cls == OPC_ADD_LIT |=> acc == 8'($past(acc) + $past(instr[7:0])))
    else $error("add literal result wrong");
  a_sub_lit_carry: assert property (cls == OPC_SUB_LIT |=> carry_flag == ($past(instr[7:0]) >= $past(acc)))
    else $error("subtract carry not inverted borrow");
  a_sub_file_val: assert property (cls == OPC_SUB_FILE && !dest_file
    |=> acc == 8'($past(file_rdata) - $past(acc)))
    else $error("subtract file result wrong");
  a_and_lit_flags: assert property (cls == OPC_AND_LIT |=> $stable(carry_flag) && $stable(half_carry_flag)
    && zero_flag == (acc == 8'h00))
    else $error("and literal flags wrong");
  a_dest_file_keep: assert property (file_op && dest_file |-> file_we ##1 $stable(acc))
    else $error("file destination touched accumulator");
  a_store_acc: assert property (is_store |-> file_we && file_wdata == acc ##1 $stable(zero_flag))
    else $error("store accumulator wrong");
  a_inc_flags: assert property (is_inc |=> $stable(zero_flag) && $stable(carry_flag))
    else $error("increment changed flags");
  a_load_lit: assert property (cls == OPC_LOAD_LIT |=> acc == $past(instr[7:0]) && $stable(zero_flag))
    else $error("load literal wrong");
  a_opt_load: assert property (is_opt |=> opt_cfg == $past(acc))
    else $error("option load wrong");
  a_copy_zero: assert property (cls == OPC_COPY_FILE |=> zero_flag == ($past(file_rdata) == 8'h00))
    else $error("copy file zero flag wrong");

  // --------------------------------------------------------------
  // Skip slot and increment checks
  // --------------------------------------------------------------
  sequence s_slot_discarded;
    !file_we && (cls == OPC_NONE);
  endsequence

  sequence s_flags_held;
    $stable(carry_flag) && $stable(half_carry_flag) && $stable(zero_flag);
  endsequence

  a_slot_no_write: assert property (skip_active |-> s_slot_discarded)
    else $error("discarded word was executed");
  a_slot_keeps_flags: assert property (skip_active |=> s_flags_held)
    else $error("discarded word changed flags");
  a_slot_keeps_acc: assert property (skip_active |=> $stable(acc) && $stable(opt_cfg))
    else $error("discarded word changed accumulator");
  a_slot_single: assert property (skip_active |=> !skip_active)
    else $error("skip slot lasted more than one cycle");
  a_slot_cause: assert property ($rose(skip_active) |-> $past(is_inc) && ($past(file_rdata) == 8'hff))
    else $error("skip slot without zero increment");
  a_inc_to_acc: assert property (is_inc && !dest_file |=> acc == 8'($past(file_rdata) + 8'h01))
    else $error("increment to accumulator wrong");
  a_inc_to_file: assert property (is_inc && dest_file
    |-> file_we && file_wdata == 8'(file_rdata + 8'h01))
    else $error("increment to file wrong");
  a_inc_keeps_half: assert property (is_inc |=> $stable(half_carry_flag))
    else $error("increment changed half carry");

  // --------------------------------------------------------------
  // Arithmetic checks
  // --------------------------------------------------------------
  a_add_lit_carry: assert property (cls == OPC_ADD_LIT
    |=> carry_flag == ((9'($past(acc)) + 9'($past(instr[7:0]))) > 9'h0ff))
    else $error("add literal carry wrong");
  a_add_lit_half: assert property (cls == OPC_ADD_LIT
    |=> half_carry_flag == ((5'($past(acc[3:0])) + 5'($past(instr[3:0]))) > 5'h0f))
    else $error("add literal half carry wrong");
  a_add_lit_zero: assert property (cls == OPC_ADD_LIT |=> zero_flag == (acc == 8'h00))
    else $error("add literal zero flag wrong");
  a_add_file_acc: assert property (cls == OPC_ADD_FILE && !dest_file
    |=> acc == 8'($past(file_rdata) + $past(acc)))
    else $error("add file result wrong");
  a_add_file_carry: assert property (cls == OPC_ADD_FILE
    |=> carry_flag == ((9'($past(file_rdata)) + 9'($past(acc))) > 9'h0ff))
    else $error("add file carry wrong");
  a_add_file_back: assert property (cls == OPC_ADD_FILE && dest_file
    |-> file_we && file_wdata == 8'(file_rdata + acc))
    else $error("add file write back wrong");
  a_sub_lit_val: assert property (cls == OPC_SUB_LIT |=> acc == 8'($past(instr[7:0]) - $past(acc)))
    else $error("subtract literal result wrong");
  a_sub_lit_zero: assert property (cls == OPC_SUB_LIT |=> zero_flag == (acc == 8'h00))
    else $error("subtract literal zero flag wrong");
  a_sub_file_carry: assert property (cls == OPC_SUB_FILE
    |=> carry_flag == ($past(file_rdata) >= $past(acc)))
    else $error("subtract file carry not inverted borrow");
  a_sub_half_borrow: assert property (cls == OPC_SUB_FILE
    |=> half_carry_flag == ($past(file_rdata[3:0]) >= $past(acc[3:0])))
    else $error("subtract half carry not inverted nibble borrow");
  a_sub_file_back: assert property (cls == OPC_SUB_FILE && dest_file
    |-> file_we && file_wdata == 8'(file_rdata - acc))
    else $error("subtract file write back wrong");

  // --------------------------------------------------------------
  // Logic, move and routing checks
  // --------------------------------------------------------------
  a_and_lit_val: assert property (cls == OPC_AND_LIT |=> acc == ($past(acc) & $past(instr[7:0])))
    else $error("and literal result wrong");
  a_and_file_flags: assert property (cls == OPC_AND_FILE
    |=> zero_flag == (($past(acc) & $past(file_rdata)) == 8'h00) && $stable(carry_flag))
    else $error("and file flags wrong");
  a_and_file_back: assert property (cls == OPC_AND_FILE && dest_file
    |-> file_we && file_wdata == (acc & file_rdata))
    else $error("and file write back wrong");
  a_or_file_acc: assert property (cls == OPC_OR_FILE && !dest_file
    |=> acc == ($past(acc) | $past(file_rdata)) && $stable(half_carry_flag))
    else $error("or file result wrong");
  a_or_lit_val: assert property (cls == OPC_OR_LIT
    |=> acc == ($past(acc) | $past(instr[7:0])) && zero_flag == (acc == 8'h00))
    else $error("or literal result wrong");
  a_copy_to_acc: assert property (cls == OPC_COPY_FILE && !dest_file |=> acc == $past(file_rdata))
    else $error("copy file to accumulator wrong");
  a_copy_to_file: assert property (cls == OPC_COPY_FILE && dest_file
    |-> file_we && file_wdata == file_rdata)
    else $error("copy file write back wrong");
  a_store_keeps: assert property (is_store |=> $stable(acc) && $stable(carry_flag))
    else $error("store accumulator changed state");
  a_dest_acc_quiet: assert property (file_op && !dest_file |-> !file_we)
    else $error("accumulator destination wrote file");
  a_lit_quiet: assert property (is_lit |-> !file_we)
    else $error("literal instruction wrote file");
  a_opt_quiet: assert property (is_opt |-> !file_we ##1 s_flags_held)
    else $error("option load touched file or flags");
  a_opt_held: assert property (!is_opt |=> $stable(opt_cfg))
    else $error("option register changed without option load");
  a_unknown_noop: assert property (cls == OPC_NONE && !is_store && !is_opt
    |=> $stable(acc) && $stable(zero_flag))
    else $error("unknown word changed state");
endmodule

// File: tb/file_mem_model.sv
`timescale 1ns/1ps
// ------------------------------
// Data register file behind the datapath
// ------------------------------
module file_mem_model (
  // Clock
  input wire logic sys_clk,
  // Access port
  input wire logic [6:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [0:127];
  // Known fill so no unknown reaches the datapath
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  assign file_rdata = mem[file_addr];
  always @(posedge sys_clk) begin
    if (file_we) begin
      mem[file_addr] <= file_wdata;
    end
  end
endmodule

// File: tb/lit_file_alu_tb_top.sv
`timescale 1ns/1ps
module lit_file_alu_tb_top;
  import lit_alu_pkg::*;
  logic sys_clk, rstn, file_we, carry_flag, half_carry_flag, zero_flag, skip_active;
  logic [13:0] instr;
  logic [7:0] file_rdata, file_wdata, acc, opt_cfg, wv, rv;
  logic [6:0] file_addr;
  logic [2:0] fl;
  logic [7:0] fexp [0:127];
  int error_cnt, check_count;
  lit_file_alu lit_file_alu_inst (.sys_clk(sys_clk), .rstn(rstn), .instr(instr), .file_rdata(file_rdata),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .acc(acc), .opt_cfg(opt_cfg),
    .carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
    .skip_active(skip_active));
  file_mem_model file_mem_model_inst (.sys_clk(sys_clk), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .file_rdata(file_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_flags(input logic [2:0] e);
    check_count++;
    if ({carry_flag, half_carry_flag, zero_flag} !== e) begin
      error_cnt++;
      $display("mismatch flags expected %b seen %b", e, {carry_flag, half_carry_flag, zero_flag});
    end
  endtask
  // ------------------------------
  // Instruction drivers and expectations
  // ------------------------------
  task automatic step(input logic [13:0] w);
    instr = w;
    @(posedge sys_clk);
    #1;
    chk_byte("acc", wv, acc);
    chk_flags(fl);
  endtask
  task automatic arith(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + 9'(cin);
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin);
    rv = s[7:0];
    fl = {s[8], h[4], s[7:0] == 8'h00};
  endtask
  task automatic logic_res(input logic [7:0] r);
    rv = r;
    fl[0] = (r == 8'h00);
  endtask
  task automatic put(input logic [6:0] a, input logic [7:0] v);
    wv = v;
    step({6'h30, v});
    fexp[a] = v;
    step({7'h01, a});
    chk_byte("file", v, file_mem_model_inst.mem[a]);
  endtask
  task automatic fop(input logic [5:0] op, input logic d, input logic [6:0] a);
    if (d) fexp[a] = rv;
    else wv = rv;
    step({op, d, a});
    chk_byte("file", fexp[a], file_mem_model_inst.mem[a]);
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset();
    chk_byte("acc", 8'h00, acc);
    chk_byte("opt", 8'hff, opt_cfg);
    chk_flags(3'b000);
    chk_byte("skip", 8'h00, {7'h00, skip_active});
    $display("test reset done");
  endtask
  task automatic t_literal();
    wv = 8'h10;
    step(14'h3310);
    arith(wv, 8'h15, 1'b0);
    wv = rv;
    step(14'h3e15);
    arith(wv, 8'hdb, 1'b0);
    wv = rv;
    step(14'h3fdb);
    put(7'h10, 8'ha3);
    logic_res(wv & 8'h5f);
    wv = rv;
    step(14'h395f);
    logic_res(wv | 8'h35);
    wv = rv;
    step(14'h3835);
    for (int i = 1; i < 4; i++) begin
      put(7'h11, 8'(i));
      arith(8'h02, ~wv, 1'b1);
      wv = rv;
      step({5'h1e, 1'(i), 8'h02});
    end
    $display("test literal done");
  endtask
  task automatic t_file();
    put(7'h20, 8'hc2);
    put(7'h12, 8'h17);
    arith(wv, fexp[7'h20], 1'b0);
    fop(6'h07, 1'b0, 7'h20);
    put(7'h12, 8'h17);
    arith(wv, fexp[7'h20], 1'b0);
    fop(6'h07, 1'b1, 7'h20);
    logic_res(wv & fexp[7'h20]);
    fop(6'h05, 1'b1, 7'h20);
    logic_res(wv | fexp[7'h20]);
    fop(6'h04, 1'b0, 7'h20);
    put(7'h21, 8'h00);
    logic_res(fexp[7'h21]);
    fop(6'h08, 1'b1, 7'h21);
    logic_res(fexp[7'h20]);
    fop(6'h08, 1'b0, 7'h20);
    for (int i = 3; i > 0; i--) begin
      put(7'h22, 8'(i));
      put(7'h13, 8'h02);
      arith(fexp[7'h22], ~wv, 1'b1);
      fop(6'h02, 1'(i), 7'h22);
    end
    $display("test file done");
  endtask
  task automatic t_skip();
    put(7'h31, 8'h66);
    put(7'h30, 8'hff);
    rv = 8'h00;
    fop(6'h0f, 1'b1, 7'h30);
    chk_byte("skip", 8'h01, {7'h00, skip_active});
    instr = {7'h01, 7'h31};
    #1;
    chk_byte("we", 8'h00, {7'h00, file_we});
    step({7'h01, 7'h31});
    chk_byte("file", fexp[7'h31], file_mem_model_inst.mem[7'h31]);
    chk_byte("skip", 8'h00, {7'h00, skip_active});
    put(7'h30, 8'h41);
    rv = 8'h42;
    fop(6'h0f, 1'b0, 7'h30);
    chk_byte("skip", 8'h00, {7'h00, skip_active});
    $display("test skip done");
  endtask
  task automatic t_option();
    put(7'h32, 8'h4f);
    step(14'h0062);
    chk_byte("opt", 8'h4f, opt_cfg);
    put(7'h33, 8'h5a);
    step(14'h3aaf);
    step(14'h0eb3);
    chk_byte("file", fexp[7'h33], file_mem_model_inst.mem[7'h33]);
    $display("test option done");
  endtask
  task automatic t_mid_reset();
    put(7'h34, 8'hff);
    rv = 8'h00;
    fop(6'h0f, 1'b0, 7'h34);
    rstn = 1'b0;
    @(posedge sys_clk);
    #1;
    t_reset();
    rstn = 1'b1;
    wv = 8'h00;
    fl = 3'b000;
    step({7'h01, 7'h34});
    chk_byte("file", 8'h00, file_mem_model_inst.mem[7'h34]);
    $display("test mid reset done");
  endtask
  initial begin
    #50000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    error_cnt = 0;
    check_count = 0;
    rstn = 1'b0;
    instr = 14'h0000;
    fl = 3'b000;
    repeat (4) @(posedge sys_clk);
    #1;
    t_reset();
    rstn = 1'b1;
    t_literal();
    t_file();
    t_skip();
    t_option();
    t_mid_reset();
    print_verdict();
  end
endmodule
